// ===== hdl/cscr_pkg.sv
/*
 core system control register set: offsets, field positions, reset values, command codes.
 assumes a single 8-bit register port driven by the core's instruction stream.
*/
package cscr_pkg;
   localparam logic [7:0] OFS_INT_CTRL    = 8'he6;
   localparam logic [7:0] OFS_FLAGS       = 8'he7;
   localparam logic [7:0] OFS_PTR_ZERO    = 8'he8;
   localparam logic [7:0] OFS_PTR_ONE     = 8'he9;
   localparam logic [7:0] RST_INT_CTRL    = 8'h87;
   localparam logic [7:0] RST_FLAGS       = 8'h00;
   localparam logic [7:0] RST_PTR         = 8'h00;
   localparam int         IC_RSVD_BIT     = 7;
   localparam int         IC_PEND_BIT     = 6;
   localparam int         IC_GATE_BIT     = 5;
   localparam int         IC_GEN_BIT      = 4;
   localparam int         IC_ARB_BIT      = 3;
   localparam int         FL_C_BIT        = 7;
   localparam int         FL_Z_BIT        = 6;
   localparam int         FL_S_BIT        = 5;
   localparam int         FL_V_BIT        = 4;
   localparam int         FL_BCD_BIT      = 3;
   localparam int         FL_H_BIT        = 2;
   localparam int         FL_RSVD_BIT     = 1;
   localparam int         FL_DSP_BIT      = 0;
   localparam int         PTR_MODE_BIT    = 2;
   localparam int         NEST_DEPTH      = 7;
   // core commands on cmd_i
   typedef enum logic [3:0] {
      CSCR_NOP, CSCR_SET_C, CSCR_CLR_C, CSCR_CPL_C, CSCR_SDM, CSCR_SPM,
      CSCR_UNMASK, CSCR_MASK_ALL, CSCR_SRP, CSCR_SET_LOW_TWIN, CSCR_SET_HIGH_TWIN
   } cscr_cmd_t;
endpackage : cscr_pkg

// ===== hdl/cscr_core.sv
/*
 core system control registers: interrupt control, status flags, working-register pointers.
 assumes strobes are one cycle and never together; alu results arrive with alu_upd_i.
*/
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cscr_core (
   input  wire logic        clock_i,
   input  wire logic        sys_rst_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   input  wire logic [3:0]  cmd_i,
   input  wire logic [4:0]  cmd_block_i,
   input  wire logic        top_irq_req_i,
   input  wire logic        top_irq_mask_i,
   input  wire logic        irq_ack_i,
   input  wire logic [2:0]  irq_ack_level_i,
   input  wire logic        irq_ret_i,
   input  wire logic        src_irq_req_i,
   input  wire logic [2:0]  src_irq_level_i,
   input  wire logic        alu_upd_i,
   input  wire logic        alu_word_i,
   input  wire logic        alu_sub_i,
   input  wire logic        alu_bcd_i,
   input  wire logic        alu_carry_upd_i,
   input  wire logic [15:0] alu_a_i,
   input  wire logic [15:0] alu_b_i,
   input  wire logic [15:0] alu_res_i,
   input  wire logic        alu_carry_i,
   input  wire logic [3:0]  wreg_i,
   output logic      [7:0]  wreg_addr_o,
   output logic             top_irq_take_o,
   output logic             src_irq_take_o,
   output logic             nested_mode_o,
   output logic             data_space_o,
   output logic      [2:0]  nesting_save_o,
   output logic             flag_stack_full_o
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] interrupt_ctrl_reg;
   logic       top_irq_pending_ff;
   logic       top_irq_gate_sel_ff;
   logic       irq_global_enable_ff;
   logic       arbitration_mode_sel_ff;
   logic [2:0] cpl_ff;
   logic [7:0] status_flags_reg_ff;
   logic [7:0] pointer_zero_reg_ff;
   logic [7:0] pointer_one_reg_ff;
   logic [7:0] rdata_ff;
   logic [2:0] nesting_save_ff;
   logic [7:0] flag_stack_ff [cscr_pkg::NEST_DEPTH];
   logic [2:0] stack_cnt_ff;
   logic [7:0] nxt_flags;
   logic       gen;
   logic [2:0] cpl;
   logic       wr_ic;
   logic       wr_fl;
   logic       res_zero;
   logic       res_sign;
   logic       a_top;
   logic       b_top;
   logic       b_eff;
   logic       half;
   cscr_pkg::cscr_cmd_t cmd;

   assign cmd   = cscr_pkg::cscr_cmd_t'(cmd_i);
   assign gen   = irq_global_enable_ff;
   assign cpl   = cpl_ff;
   assign wr_ic = wr_i && (addr_i == cscr_pkg::OFS_INT_CTRL);
   assign wr_fl = wr_i && (addr_i == cscr_pkg::OFS_FLAGS);

   ////////////////////////////////////////////////////////////////////////////
   // gating of top level
   assign top_irq_take_o = top_irq_pending_ff && top_irq_mask_i &&
                           (!top_irq_gate_sel_ff || gen);
   assign src_irq_take_o = src_irq_req_i && gen && (src_irq_level_i < cpl);
   assign nested_mode_o  = arbitration_mode_sel_ff;
   assign data_space_o   = status_flags_reg_ff[cscr_pkg::FL_DSP_BIT];
   assign nesting_save_o = nesting_save_ff;
   assign flag_stack_full_o = (stack_cnt_ff == 3'(cscr_pkg::NEST_DEPTH));
   assign rdata_o        = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // interrupt control, one field per process except gate and arbitration selects, which share one
   // reserved bit not stored, reads one
   assign interrupt_ctrl_reg = {1'b1, top_irq_pending_ff, top_irq_gate_sel_ff,
                                irq_global_enable_ff, arbitration_mode_sel_ff, cpl_ff};

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         top_irq_pending_ff <= cscr_pkg::RST_INT_CTRL[cscr_pkg::IC_PEND_BIT];
      end else if (top_irq_req_i) begin
         top_irq_pending_ff <= 1'b1;
      end else if (irq_ack_i && top_irq_take_o) begin
         top_irq_pending_ff <= 1'b0;
      end else if (wr_ic) begin
         // write of one emulates a request
         top_irq_pending_ff <= wdata_i[cscr_pkg::IC_PEND_BIT];
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         top_irq_gate_sel_ff     <= cscr_pkg::RST_INT_CTRL[cscr_pkg::IC_GATE_BIT];
         arbitration_mode_sel_ff <= cscr_pkg::RST_INT_CTRL[cscr_pkg::IC_ARB_BIT];
      end else if (wr_ic) begin
         top_irq_gate_sel_ff     <= wdata_i[cscr_pkg::IC_GATE_BIT];
         arbitration_mode_sel_ff <= wdata_i[cscr_pkg::IC_ARB_BIT];
      end
   end

   // ack and return beat instructions, which beat a write
   // no interlock: software keeps writes safe
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_global_enable_ff <= cscr_pkg::RST_INT_CTRL[cscr_pkg::IC_GEN_BIT];
      end else if (irq_ack_i) begin
         irq_global_enable_ff <= 1'b0;
      end else if (irq_ret_i) begin
         irq_global_enable_ff <= 1'b1;
      end else if (cmd == cscr_pkg::CSCR_UNMASK) begin
         irq_global_enable_ff <= 1'b1;
      end else if (cmd == cscr_pkg::CSCR_MASK_ALL) begin
         irq_global_enable_ff <= 1'b0;
      end else if (wr_ic) begin
         irq_global_enable_ff <= wdata_i[cscr_pkg::IC_GEN_BIT];
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cpl_ff <= cscr_pkg::RST_INT_CTRL[2:0];
      end else if (irq_ack_i) begin
         cpl_ff <= irq_ack_level_i;
      end else if (irq_ret_i) begin
         cpl_ff <= nesting_save_ff;
      end else if (wr_ic) begin
         cpl_ff <= wdata_i[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // save preempted level; single-entry, outer levels are the controller's job
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         nesting_save_ff <= 3'h7;
      end else if (irq_ack_i) begin
         nesting_save_ff <= cpl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // alu flag terms
   always_comb begin
      res_zero = alu_word_i ? (alu_res_i == 16'h0000) : (alu_res_i[7:0] == 8'h00);
      res_sign = alu_word_i ? alu_res_i[15] : alu_res_i[7];
      a_top    = alu_word_i ? alu_a_i[15] : alu_a_i[7];
      b_top    = alu_word_i ? alu_b_i[15] : alu_b_i[7];
      b_eff    = alu_sub_i ? !b_top : b_top;
      half     = alu_a_i[4] ^ alu_b_i[4] ^ alu_res_i[4];
      nxt_flags = status_flags_reg_ff;
      if (alu_upd_i) begin
         nxt_flags[cscr_pkg::FL_Z_BIT] = res_zero;
         nxt_flags[cscr_pkg::FL_S_BIT] = res_sign;
         nxt_flags[cscr_pkg::FL_V_BIT] = (a_top == b_eff) && (res_sign != a_top);
         if (alu_bcd_i) begin
            nxt_flags[cscr_pkg::FL_BCD_BIT] = alu_sub_i;
            nxt_flags[cscr_pkg::FL_H_BIT]   = half;
         end
      end
      if (alu_carry_upd_i) begin
         nxt_flags[cscr_pkg::FL_C_BIT] = alu_carry_i;
      end
      unique case (cmd)
         cscr_pkg::CSCR_SET_C: nxt_flags[cscr_pkg::FL_C_BIT] = 1'b1;
         cscr_pkg::CSCR_CLR_C: nxt_flags[cscr_pkg::FL_C_BIT] = 1'b0;
         cscr_pkg::CSCR_CPL_C: nxt_flags[cscr_pkg::FL_C_BIT] =
            !status_flags_reg_ff[cscr_pkg::FL_C_BIT];
         cscr_pkg::CSCR_SDM:   nxt_flags[cscr_pkg::FL_DSP_BIT] = 1'b1;
         cscr_pkg::CSCR_SPM:   nxt_flags[cscr_pkg::FL_DSP_BIT] = 1'b0;
         default: ;
      endcase
      if (wr_fl) begin
         nxt_flags = wdata_i;
      end
      if (irq_ret_i && stack_cnt_ff != 3'h0) begin
         nxt_flags = flag_stack_ff[stack_cnt_ff - 3'h1];
      end
      nxt_flags[cscr_pkg::FL_RSVD_BIT] = 1'b0;
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         status_flags_reg_ff <= cscr_pkg::RST_FLAGS;
      end else begin
         status_flags_reg_ff <= nxt_flags;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flag save stack, seven deep
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stack_cnt_ff <= 3'h0;
      end else if (irq_ack_i && !flag_stack_full_o) begin
         stack_cnt_ff <= stack_cnt_ff + 3'h1;
      end else if (irq_ret_i && stack_cnt_ff != 3'h0) begin
         stack_cnt_ff <= stack_cnt_ff - 3'h1;
      end
   end

   for (genvar i = 0; i < cscr_pkg::NEST_DEPTH; i++) begin : g_stack
      always_ff @(posedge clock_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            flag_stack_ff[i] <= cscr_pkg::RST_FLAGS;
         end else if (irq_ack_i && !flag_stack_full_o && stack_cnt_ff == 3'(i)) begin
            flag_stack_ff[i] <= status_flags_reg_ff;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // working-register pointer zero
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pointer_zero_reg_ff <= cscr_pkg::RST_PTR;
      end else begin
         if (wr_i && addr_i == cscr_pkg::OFS_PTR_ZERO) begin
            pointer_zero_reg_ff <= {wdata_i[7:2], 2'b00};
         end
         unique case (cmd)
            cscr_pkg::CSCR_SRP: begin
               pointer_zero_reg_ff <= {cmd_block_i, 3'b000};
            end
            cscr_pkg::CSCR_SET_LOW_TWIN: begin
               pointer_zero_reg_ff <= {cmd_block_i, 3'b100};
            end
            cscr_pkg::CSCR_SET_HIGH_TWIN: begin
               pointer_zero_reg_ff[cscr_pkg::PTR_MODE_BIT] <= 1'b1;
            end
            default: ;
         endcase
      end
   end

   // working-register pointer one, only used in twin mode
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pointer_one_reg_ff <= cscr_pkg::RST_PTR;
      end else begin
         if (wr_i && addr_i == cscr_pkg::OFS_PTR_ONE) begin
            pointer_one_reg_ff <= {wdata_i[7:2], 2'b00};
         end
         unique case (cmd)
            cscr_pkg::CSCR_SRP: begin
               pointer_one_reg_ff[cscr_pkg::PTR_MODE_BIT] <= 1'b0;
            end
            cscr_pkg::CSCR_SET_LOW_TWIN: begin
               pointer_one_reg_ff[cscr_pkg::PTR_MODE_BIT] <= 1'b1;
            end
            cscr_pkg::CSCR_SET_HIGH_TWIN: begin
               pointer_one_reg_ff <= {cmd_block_i, 3'b100};
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // working register address, registered
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wreg_addr_o <= 8'h00;
      end else if (pointer_zero_reg_ff[cscr_pkg::PTR_MODE_BIT]) begin
         wreg_addr_o <= wreg_i[3] ? {pointer_one_reg_ff[7:3], wreg_i[2:0]}
                                  : {pointer_zero_reg_ff[7:3], wreg_i[2:0]};
      end else begin
         wreg_addr_o <= {pointer_zero_reg_ff[7:4], wreg_i};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port; unmapped reads give zero
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_ff <= 8'h00;
      end else if (rd_i) begin
         unique case (addr_i)
            cscr_pkg::OFS_INT_CTRL: rdata_ff <= interrupt_ctrl_reg;
            cscr_pkg::OFS_FLAGS:    rdata_ff <= status_flags_reg_ff;
            cscr_pkg::OFS_PTR_ZERO: rdata_ff <= pointer_zero_reg_ff;
            cscr_pkg::OFS_PTR_ONE:  rdata_ff <= pointer_one_reg_ff;
            default:                rdata_ff <= 8'h00;
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end
endmodule : cscr_core
`default_nettype wire

// ===== tb/cscr_core_props.sv
/*
 port-level checker for cscr_core.
 assumes one clock domain and the async high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cscr_core_props (
   input wire logic       clock_i,
   input wire logic       sys_rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic [3:0] cmd_i,
   input wire logic [4:0] cmd_block_i,
   input wire logic       top_irq_mask_i,
   input wire logic       irq_ack_i,
   input wire logic       irq_ret_i,
   input wire logic [3:0] wreg_i,
   input wire logic [7:0] wreg_addr_o,
   input wire logic       top_irq_take_o,
   input wire logic       src_irq_take_o,
   input wire logic       nested_mode_o,
   input wire logic       data_space_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   ////////////////////////////////////////
   // reserved bit high
   property p_rsvd; rd_i && addr_i == 8'he6 |=> rdata_o[7]; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit low");
   property p_plow; rd_i && addr_i[7:1] == 7'h74 |=> rdata_o[1:0] == 2'h0; endproperty
   a_plow: assert property (p_plow) else $error("pointer low bits set");
   property p_gate; top_irq_take_o |-> top_irq_mask_i; endproperty
   a_gate: assert property (p_gate) else $error("top take without mask");
   property p_pend;
      wr_i && addr_i == 8'he6 && wdata_i[6] && !wdata_i[5] && !irq_ack_i ##1 top_irq_mask_i
         |-> top_irq_take_o;
   endproperty
   a_pend: assert property (p_pend) else $error("pending write not taken");
   property p_ack; irq_ack_i |=> !src_irq_take_o; endproperty
   a_ack: assert property (p_ack) else $error("source taken after ack");
   property p_arb;
      wr_i && addr_i == 8'he6 |=> nested_mode_o == |($past(wdata_i) & 8'h08);
   endproperty
   a_arb: assert property (p_arb) else $error("arbitration mode wrong");
   property p_dsp; cmd_i == 4'h4 && !wr_i && !irq_ret_i |=> data_space_o; endproperty
   a_dsp: assert property (p_dsp) else $error("data space not set");
   property p_single;
      cmd_i == 4'h8 ##1 (cmd_i == 4'h0 && !wr_i) |=> wreg_addr_o[7:4] ==
         ($past(cmd_block_i, 2) >> 1) && wreg_addr_o[3:0] == $past(wreg_i);
   endproperty
   a_single: assert property (p_single) else $error("single map wrong");
   property p_twin;
      cmd_i == 4'ha ##1 (cmd_i == 4'h0 && !wr_i && wreg_i[3]) |=> wreg_addr_o[7:3] ==
         $past(cmd_block_i, 2) && wreg_addr_o[2:0] == ($past(wreg_i) & 4'h7);
   endproperty
   a_twin: assert property (p_twin) else $error("twin map wrong");
endmodule : cscr_core_props
bind cscr_core cscr_core_props u_props (.clock_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i,
   .rd_i, .rdata_o, .cmd_i, .cmd_block_i, .top_irq_mask_i, .irq_ack_i, .irq_ret_i,
   .wreg_i, .wreg_addr_o, .top_irq_take_o, .src_irq_take_o, .nested_mode_o, .data_space_o);
`default_nettype wire

// ===== tb/cscr_core_test.sv
/*
 self-checking bench for cscr_core.
 assumes the command codes and offsets of cscr_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
module cscr_core_test;
   localparam logic [1:0] W = 2'b10, R = 2'b01, N = 2'b00;
   localparam logic [7:0] IC = 8'he6, FL = 8'he7, P0 = 8'he8, P1 = 8'he9;
   logic        clock_i, sys_rst_i, wr_i, rd_i, top_irq_req_i, top_irq_mask_i;
   logic        irq_ack_i, irq_ret_i, src_irq_req_i, alu_upd_i, alu_word_i, alu_sub_i;
   logic        alu_bcd_i, alu_carry_upd_i, alu_carry_i, top_irq_take_o, src_irq_take_o;
   logic        nested_mode_o, data_space_o, flag_stack_full_o;
   logic [7:0]  addr_i, wdata_i, rdata_o, wreg_addr_o;
   logic [3:0]  cmd_i, wreg_i;
   logic [4:0]  cmd_block_i;
   logic [2:0]  irq_ack_level_i, src_irq_level_i, nesting_save_o;
   logic [15:0] alu_a_i, alu_b_i, alu_res_i;
   int          err_total, check_count;
   cscr_core dut (.clock_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cmd_i,
      .cmd_block_i, .top_irq_req_i, .top_irq_mask_i, .irq_ack_i, .irq_ack_level_i,
      .irq_ret_i, .src_irq_req_i, .src_irq_level_i, .alu_upd_i, .alu_word_i, .alu_sub_i,
      .alu_bcd_i, .alu_carry_upd_i, .alu_a_i, .alu_b_i, .alu_res_i, .alu_carry_i, .wreg_i,
      .wreg_addr_o, .top_irq_take_o, .src_irq_take_o, .nested_mode_o, .data_space_o,
      .nesting_save_o, .flag_stack_full_o);
   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   ////////////////////////////////////////
   // one transfer, taken at the next edge; pulses drop there
   task automatic op(input logic [1:0] k, input logic [7:0] a, d,
                     input logic [3:0] c = 4'h0, input logic [4:0] b = 5'h0);
      wr_i <= k[1];
      rd_i <= k[0];
      addr_i <= a;
      wdata_i <= d;
      cmd_i <= c;
      cmd_block_i <= b;
      @(posedge clock_i);
      {wr_i, rd_i, cmd_i, irq_ack_i, irq_ret_i, top_irq_req_i, alu_upd_i, alu_carry_upd_i} <= '0;
      #1;
   endtask : op
   task automatic rdc(input logic [7:0] a, e);
      op(R, a, 8'h00);
      `CHK(rdata_o, e)
   endtask : rdc
   task automatic wchk(input logic [3:0] w, input logic [7:0] e);
      wreg_i <= w;
      op(N, 8'h00, 8'h00);
      `CHK(wreg_addr_o, e)
   endtask : wchk
   task automatic alu(input logic w, s, bcd, cy, input logic [15:0] a, b, r,
                      input logic [7:0] e);
      {alu_word_i, alu_sub_i, alu_bcd_i, alu_carry_i} <= {w, s, bcd, cy};
      {alu_a_i, alu_b_i, alu_res_i} <= {a, b, r};
      alu_upd_i <= 1'b1;
      alu_carry_upd_i <= !bcd;
      op(N, 8'h00, 8'h00);
      rdc(FL, e);
   endtask : alu
   ////////////////////////////////////////
   task automatic t_reset;
      rdc(IC, 8'h87);
      rdc(FL, 8'h00);
      rdc(8'he5, 8'h00);
      op(W, IC, 8'h00);
      rdc(IC, 8'h80);
   endtask : t_reset
   task automatic t_top;
      top_irq_mask_i <= 1'b1;
      op(W, IC, 8'he0);
      `CHK(top_irq_take_o, 1'b0)
      op(N, 8'h00, 8'h00, cscr_pkg::CSCR_UNMASK);
      `CHK(top_irq_take_o, 1'b1)
      rdc(IC, 8'hf0);
      op(W, IC, 8'h80);
      top_irq_req_i <= 1'b1;
      op(N, 8'h00, 8'h00);
      `CHK(top_irq_take_o, 1'b1)
      top_irq_mask_i <= 1'b0;
      #1 `CHK(top_irq_take_o, 1'b0)
      rdc(IC, 8'hc0);
   endtask : t_top
   task automatic t_ack;
      op(W, IC, 8'h93);
      op(W, FL, 8'h81);
      {src_irq_req_i, src_irq_level_i} <= {1'b1, 3'd1};
      #1 `CHK(src_irq_take_o, 1'b1)
      src_irq_level_i <= 3'd5;
      #1 `CHK(src_irq_take_o, 1'b0)
      {irq_ack_i, irq_ack_level_i, src_irq_level_i} <= {1'b1, 3'd1, 3'd0};
      op(N, 8'h00, 8'h00);
      `CHK(src_irq_take_o, 1'b0)
      `CHK(nesting_save_o, 3'd3)
      rdc(IC, 8'h81);
      op(W, FL, 8'h00);
      irq_ret_i <= 1'b1;
      op(N, 8'h00, 8'h00);
      `CHK(src_irq_take_o, 1'b1)
      rdc(IC, 8'h93);
      rdc(FL, 8'h81);
      src_irq_req_i <= 1'b0;
   endtask : t_ack
   task automatic t_cmds;
      logic [3:0] c [8] = '{4'h1, 4'h3, 4'h3, 4'h2, 4'h5, 4'h4, 4'h7, 4'h6};
      logic [7:0] e [8] = '{8'h81, 8'h01, 8'h81, 8'h01, 8'h00, 8'h01, 8'h83, 8'h93};
      op(W, FL, 8'h01);
      for (int i = 0; i < 8; i++) begin
         op(N, 8'h00, 8'h00, c[i]);
         rdc((i < 6) ? FL : IC, e[i]);
      end
      `CHK(data_space_o, 1'b1)
   endtask : t_cmds
   task automatic t_alu;
      alu(0, 0, 0, 1, 16'h0080, 16'h0080, 16'h0000, 8'hd1);
      alu(1, 0, 0, 0, 16'h7fff, 16'h0001, 16'h8000, 8'h31);
      alu(0, 1, 1, 0, 16'h0010, 16'h0001, 16'h000f, 8'h0d);
      alu(0, 0, 1, 0, 16'h0008, 16'h0008, 16'h0010, 8'h05);
   endtask : t_alu
   task automatic t_ptr;
      op(N, 8'h00, 8'h00, cscr_pkg::CSCR_SRP, 5'd3);
      wchk(4'h5, 8'h15);
      wchk(4'hf, 8'h1f);
      op(N, 8'h00, 8'h00, cscr_pkg::CSCR_SET_LOW_TWIN, 5'd4);
      op(N, 8'h00, 8'h00, cscr_pkg::CSCR_SET_HIGH_TWIN, 5'd9);
      rdc(P0, 8'h24);
      rdc(P1, 8'h4c);
      wchk(4'h2, 8'h22);
      wchk(4'ha, 8'h4a);
      op(W, P0, 8'hff);
      rdc(P0, 8'hfc);
   endtask : t_ptr
   task automatic t_nest;
      top_irq_mask_i <= 1'b1;
      op(W, IC, 8'h48);
      `CHK(nested_mode_o, 1'b1)
      `CHK(top_irq_take_o, 1'b1)
      for (int i = 0; i < 7; i++) begin
         `CHK(flag_stack_full_o, 1'b0)
         op(W, FL, 8'(i << 4));
         irq_ack_i <= 1'b1;
         op(N, 8'h00, 8'h00);
      end
      `CHK(flag_stack_full_o, 1'b1)
      `CHK(top_irq_take_o, 1'b0)
      for (int i = 6; i >= 0; i--) begin
         irq_ret_i <= 1'b1;
         op(N, 8'h00, 8'h00);
         rdc(FL, 8'(i << 4));
      end
      `CHK(flag_stack_full_o, 1'b0)
      top_irq_mask_i <= 1'b0;
      op(W, IC, 8'h80);
      `CHK(nested_mode_o, 1'b0)
   endtask : t_nest
   task automatic results;
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   ////////////////////////////////////////
   initial begin
      {wr_i, rd_i, top_irq_req_i, top_irq_mask_i, irq_ack_i, irq_ret_i, src_irq_req_i,
       alu_upd_i, alu_word_i, alu_sub_i, alu_bcd_i, alu_carry_upd_i, alu_carry_i, addr_i,
       wdata_i, cmd_i, wreg_i, cmd_block_i, irq_ack_level_i, src_irq_level_i, alu_a_i,
       alu_b_i, alu_res_i} = '0;
      sys_rst_i = 1'b1;
      repeat (20) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      #1;
      t_reset();
      t_top();
      t_ack();
      t_cmds();
      t_alu();
      t_ptr();
      t_nest();
      results();
   end
   // a hang ends the run as a failure
   initial begin
      repeat (20000) @(posedge clock_i);
      err_total++;
      $display("[ERR] %0t timeout", $time);
      results();
   end
endmodule : cscr_core_test
`default_nettype wire
